// file: src/gpsl_top.sv
// gpsl_top: ten-pin configurable bank with status indicator on the first pin
//
// How it works
// - input pin is read-only; read returns the sampled pad level
// - output pin takes writes setting pad level; read returns set value
// - alternate-function pin is driven by internal function logic, not writes
// - output pin drives both levels, push-pull, enable always on
// - indicator is pin zero alternate function, routed only when selected
// - indicator pin level is inverse of LED state
// - registered idle: LED on one second, off two seconds, repeating
// - dial-up: same one second on, two seconds off pattern
// - idle with power saving: indicator updates only on wake-up events
// - LED steady on unregistered or in voice call, steady off when off
`timescale 1ns/100ps
module gpsl_top #(
  parameter logic [gpsl_pkg::CNT_W-1:0] ON_CYC  = gpsl_pkg::ON_CYC,
  parameter logic [gpsl_pkg::CNT_W-1:0] OFF_CYC = gpsl_pkg::OFF_CYC
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST_B,
  // pads
  input  wire logic [gpsl_pkg::NPINS-1:0]    PAD_IN,
  output wire logic [gpsl_pkg::NPINS-1:0]    PAD_OUT,
  output wire logic [gpsl_pkg::NPINS-1:0]    PAD_OE,
  // pin configuration
  input  wire logic                          CFG_WR,
  input  wire logic [gpsl_pkg::PIN_W-1:0]    CFG_PIN,
  input  wire logic [1:0]                    CFG_MODE,
  // output level writes
  input  wire logic                          OUT_WR,
  input  wire logic [gpsl_pkg::PIN_W-1:0]    OUT_PIN,
  input  wire logic                          OUT_LEVEL,
  // read-back
  output wire logic [gpsl_pkg::NPINS-1:0]    RD_LEVEL,
  output wire logic [2*gpsl_pkg::NPINS-1:0]  RD_MODE,
  // other alternate functions
  input  wire logic [gpsl_pkg::NPINS-1:0]    ALT_OUT,
  input  wire logic [gpsl_pkg::NPINS-1:0]    ALT_OE,
  // device status for the indicator
  input  wire logic [2:0]                    DEV_STATE,
  input  wire logic                          WAKE_EVT,
  output wire logic                          STAT_LED_ON
);

  typedef struct packed {
    logic [gpsl_pkg::NPINS-1:0][1:0] mode;
    logic [gpsl_pkg::NPINS-1:0]      out_val;
    logic [gpsl_pkg::NPINS-1:0]      meta;
    logic [gpsl_pkg::NPINS-1:0]      pad_s;
    logic [gpsl_pkg::NPINS-1:0]      rd;
    logic [gpsl_pkg::NPINS-1:0]      po;
    logic [gpsl_pkg::NPINS-1:0]      poe;
    logic                            led;
  } gpsl_st_t;

  gpsl_st_t s_q;
  gpsl_st_t s_d;

  logic     rst_meta_q;
  logic     rst_n;

  gpsl_led_if led_if ();

  // ==========================================================================
  // reset release
  // assertion is immediate, release waits two edges to avoid a torn exit
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ==========================================================================
  // indicator pattern
  assign led_if.dev_state = gpsl_pkg::gpsl_dev_t'(DEV_STATE);
  assign led_if.wake      = WAKE_EVT;

  gpsl_led #(
    .ON_CYC  (ON_CYC),
    .OFF_CYC (OFF_CYC)
  ) u_led (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .led   (led_if.gen)
  );

  // ==========================================================================
  // next state
  always_comb
  begin
    s_d = s_q;

    // pads are asynchronous: two stages before anything looks at them
    s_d.meta  = PAD_IN;
    s_d.pad_s = s_q.meta;

    // mode 3 is not a valid selection and leaves the pin as it was
    if (CFG_WR && gpsl_pkg::pin_ok(CFG_PIN) && (CFG_MODE != 2'h3))
    begin
      s_d.mode[CFG_PIN] = CFG_MODE;
    end

    // level is kept even while not an output, so it can be preset
    if (OUT_WR && gpsl_pkg::pin_ok(OUT_PIN))
    begin
      s_d.out_val[OUT_PIN] = OUT_LEVEL;
    end

    s_d.led = led_if.led_on;

    for (int unsigned i = 0; i < gpsl_pkg::NPINS; i++)
    begin
      case (gpsl_pkg::mode_of(s_q.mode, i))
        gpsl_pkg::MODE_OUT:
        begin
          s_d.po[i]  = s_q.out_val[i];
          s_d.poe[i] = 1'b1;
          s_d.rd[i]  = s_q.out_val[i];
        end
        gpsl_pkg::MODE_ALT:
        begin
          if (i == gpsl_pkg::STAT_PIN)
          begin
            // inverting transistor outside: pad low lights the LED
            s_d.po[i]  = ~led_if.led_on;
            s_d.poe[i] = 1'b1;
          end
          else
          begin
            s_d.po[i]  = ALT_OUT[i];
            s_d.poe[i] = ALT_OE[i];
          end
          s_d.rd[i] = s_q.pad_s[i];
        end
        default:
        begin
          s_d.po[i]  = 1'b0;
          s_d.poe[i] = 1'b0;
          s_d.rd[i]  = s_q.pad_s[i];
        end
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.mode    <= {gpsl_pkg::NPINS{gpsl_pkg::MODE_RST}};
      s_q.out_val <= {gpsl_pkg::NPINS{gpsl_pkg::OUT_RST}};
      s_q.meta    <= '0;
      s_q.pad_s   <= '0;
      s_q.rd      <= '0;
      s_q.po      <= '0;
      s_q.poe     <= '0;
      s_q.led     <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  assign PAD_OUT     = s_q.po;
  assign PAD_OE      = s_q.poe;
  assign RD_LEVEL    = s_q.rd;
  assign RD_MODE     = s_q.mode;
  assign STAT_LED_ON = s_q.led;

endmodule : gpsl_top

// file: src/gpsl_pkg.sv
// gpsl_pkg: constants, encodings and helpers for the pin bank with status indicator
package gpsl_pkg;

  // ==========================================================================
  // bank shape
  localparam int unsigned NPINS     = 10;
  localparam int unsigned PIN_W     = 4;
  localparam int unsigned STAT_PIN  = 0;   // first pin of the bank carries the indicator

  // ==========================================================================
  // pin modes, same numbering as the configuration command
  localparam logic [1:0] MODE_IN    = 2'h0;
  localparam logic [1:0] MODE_OUT   = 2'h1;
  localparam logic [1:0] MODE_ALT   = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic [1:0] MODE_RST   = MODE_IN;
  localparam logic       OUT_RST    = 1'b0;

  // ==========================================================================
  // device status seen by the indicator
  typedef enum logic [2:0] {
    DS_OFF     = 3'h0,
    DS_NOREG   = 3'h1,
    DS_IDLE    = 3'h2,
    DS_IDLE_PS = 3'h3,
    DS_VOICE   = 3'h4,
    DS_DIALUP  = 3'h5
  } gpsl_dev_t;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned ON_TIME_MS  = 1000;
  localparam int unsigned OFF_TIME_MS = 2000;
  localparam int unsigned CNT_W       = 32;
  localparam logic [CNT_W-1:0] ON_CYC  = CNT_W'(ON_TIME_MS * (CLK_HZ / 1000));
  localparam logic [CNT_W-1:0] OFF_CYC = CNT_W'(OFF_TIME_MS * (CLK_HZ / 1000));

  // ==========================================================================
  // helpers
  function automatic logic [1:0] mode_of(input logic [NPINS-1:0][1:0] modes,
                                         input int unsigned idx);
    mode_of = modes[idx];
  endfunction : mode_of

  function automatic logic pin_ok(input logic [PIN_W-1:0] pin);
    pin_ok = (pin < PIN_W'(NPINS));
  endfunction : pin_ok

endpackage : gpsl_pkg

// file: src/gpsl_led_if.sv
// gpsl_led_if: status to indicator link between the pin bank and the pattern generator
`timescale 1ns/100ps
interface gpsl_led_if;
  gpsl_pkg::gpsl_dev_t dev_state;
  logic                wake;
  logic                led_on;

  modport ctrl (output dev_state, output wake, input led_on);
  modport gen  (input dev_state, input wake, output led_on);
endinterface : gpsl_led_if

// file: src/gpsl_led.sv
// gpsl_led: status indicator pattern generator (steady levels and blink)
`timescale 1ns/100ps
module gpsl_led #(
  parameter logic [gpsl_pkg::CNT_W-1:0] ON_CYC  = gpsl_pkg::ON_CYC,
  parameter logic [gpsl_pkg::CNT_W-1:0] OFF_CYC = gpsl_pkg::OFF_CYC
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  gpsl_led_if.gen     led
);

  typedef enum logic [2:0] {
    LS_DARK = 3'b001,
    LS_LIT  = 3'b010,
    LS_GAP  = 3'b100
  } gpsl_ls_t;

  typedef struct packed {
    gpsl_ls_t                   st;
    logic [gpsl_pkg::CNT_W-1:0] cnt;
  } gpsl_led_st_t;

  gpsl_led_st_t s_q;
  gpsl_led_st_t s_d;

  // ==========================================================================
  // pattern
  always_comb
  begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 1'b1;
    case (led.dev_state)
      gpsl_pkg::DS_NOREG, gpsl_pkg::DS_VOICE:
      begin
        s_d.st  = LS_LIT;
        s_d.cnt = '0;
      end
      gpsl_pkg::DS_IDLE, gpsl_pkg::DS_DIALUP:
      begin
        case (s_q.st)
          LS_LIT:
            if (s_q.cnt >= ON_CYC - 1'b1)
            begin
              s_d.st  = LS_GAP;
              s_d.cnt = '0;
            end
          LS_GAP:
            if (s_q.cnt >= OFF_CYC - 1'b1)
            begin
              s_d.st  = LS_LIT;
              s_d.cnt = '0;
            end
          default:
          begin
            s_d.st  = LS_LIT;
            s_d.cnt = '0;
          end
        endcase
      end
      gpsl_pkg::DS_IDLE_PS:
      begin
        // one lit period per wake-up, then dark until the next paging wake
        case (s_q.st)
          LS_LIT:
            if (s_q.cnt >= ON_CYC - 1'b1)
            begin
              s_d.st  = LS_DARK;
              s_d.cnt = '0;
            end
          default:
          begin
            s_d.cnt = '0;
            s_d.st  = led.wake ? LS_LIT : LS_DARK;
          end
        endcase
      end
      default:
      begin
        s_d.st  = LS_DARK;
        s_d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.st  <= LS_DARK;
      s_q.cnt <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign led.led_on = (s_q.st == LS_LIT);

endmodule : gpsl_led

// file: sim/gpsl_top_properties.sv
// port-level properties of the pin bank and its status indicator
`timescale 1ns/100ps
module gpsl_top_properties #(
  parameter logic [31:0] ON_CYC  = 32'h4,
  parameter logic [31:0] OFF_CYC = 32'h8
) (
  input wire logic        SYS_CLK,
  input wire logic        RST_B,
  input wire logic [9:0]  PAD_IN,
  input wire logic [9:0]  PAD_OUT,
  input wire logic [9:0]  PAD_OE,
  input wire logic        CFG_WR,
  input wire logic [3:0]  CFG_PIN,
  input wire logic [1:0]  CFG_MODE,
  input wire logic [9:0]  RD_LEVEL,
  input wire logic [19:0] RD_MODE,
  input wire logic [2:0]  DEV_STATE,
  input wire logic        WAKE_EVT,
  input wire logic        STAT_LED_ON
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // ==========================================================================
  // run counters: only runs lying wholly inside a blink state are judged
  logic        blk;
  int unsigned lit_q, dark_q, stay_q;
  assign blk = DEV_STATE == 3'h2 || DEV_STATE == 3'h5;
  always_ff @(posedge SYS_CLK or negedge RST_B)
    if (!RST_B)
    begin
      lit_q  <= 0;
      dark_q <= 0;
      stay_q <= 0;
    end
    else
    begin
      lit_q  <= STAT_LED_ON ? lit_q + 1 : 0;
      dark_q <= STAT_LED_ON ? 0 : dark_q + 1;
      stay_q <= blk ? stay_q + 1 : 0;
    end
  sequence ps_quiet;
    DEV_STATE == 3'h3 && !WAKE_EVT ##1 !STAT_LED_ON;
  endsequence
  sequence ps_woken;
    DEV_STATE == 3'h3 && WAKE_EVT ##1 !STAT_LED_ON;
  endsequence
  mode_update_a: assert property (CFG_WR && CFG_PIN < 4'ha && CFG_MODE != 2'h3 |=>
    2'(RD_MODE >> {$past(CFG_PIN), 1'b0}) == $past(CFG_MODE)) else $error("mode read-back wrong");
  in_driver_off_a: assert property (RD_MODE[3:2] == 2'h0 |=> !PAD_OE[1])
    else $error("input pin drives");
  push_pull_a: assert property (RD_MODE[3:2] == 2'h1 |=> PAD_OE[1]) else $error("output not driven");
  out_readback_a: assert property (RD_MODE[3:2] == 2'h1 |=> RD_LEVEL[1] == PAD_OUT[1])
    else $error("output read-back wrong");
  in_sample_a: assert property ((RD_MODE[3:2] == 2'h0 && $stable(PAD_IN[1]))[*4] |=>
    RD_LEVEL[1] == PAD_IN[1]) else $error("input level wrong");
  stat_pin_a: assert property (RD_MODE[1:0] == 2'h2 |=> PAD_OE[0] && PAD_OUT[0] == !STAT_LED_ON)
    else $error("indicator pin wrong");
  steady_lit_a: assert property (DEV_STATE == 3'h1 || DEV_STATE == 3'h4 |-> ##2 STAT_LED_ON)
    else $error("indicator not lit");
  steady_dark_a: assert property (DEV_STATE == 3'h0 || DEV_STATE >= 3'h6 |-> ##2 !STAT_LED_ON)
    else $error("indicator lit");
  blink_lit_a: assert property (blk && $fell(STAT_LED_ON) && stay_q >= lit_q + 2 |-> lit_q == ON_CYC)
    else $error("lit phase length wrong");
  blink_dark_a: assert property (blk && $rose(STAT_LED_ON) && stay_q >= dark_q + 2 |-> dark_q == OFF_CYC)
    else $error("dark phase length wrong");
  ps_dark_a: assert property (ps_quiet |=> !STAT_LED_ON) else $error("lit without wake");
  ps_wake_a: assert property (ps_woken |=> STAT_LED_ON) else $error("wake not shown");
endmodule : gpsl_top_properties

// file: sim/gpsl_pad_model.sv
// pad model: outside drivers on the ten pins
`timescale 1ns/100ps
module gpsl_pad_model (
  input  wire logic [9:0] pad_out,
  input  wire logic [9:0] pad_oe,
  input  wire logic [9:0] ext_lvl,
  input  wire logic [9:0] ext_en,
  output logic      [9:0] pad_in
);
  // no pull on these pads: a floating pin shows the inverse of ext_lvl
  always_comb
    for (int i = 0; i < 10; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_lvl[i] : ~ext_lvl[i]);
endmodule : gpsl_pad_model

// file: sim/gpsl_top_bench.sv
// self-checking bench for the pin bank
`timescale 1ns/100ps
module gpsl_top_bench;
  localparam logic [31:0] ON  = 32'h4;
  localparam logic [31:0] OFF = 32'h8;
  logic SYS_CLK, RST_B, CFG_WR, OUT_WR, OUT_LEVEL, WAKE_EVT, STAT_LED_ON;
  logic [3:0]  CFG_PIN, OUT_PIN;
  logic [1:0]  CFG_MODE;
  logic [2:0]  DEV_STATE;
  logic [9:0]  PAD_IN, PAD_OUT, PAD_OE, RD_LEVEL, ALT_OUT, ALT_OE, ext_lvl;
  logic [19:0] RD_MODE;
  int          n_mismatch, compares, n;
  gpsl_top #(.ON_CYC(ON), .OFF_CYC(OFF)) dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PAD_IN(PAD_IN),
    .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .CFG_WR(CFG_WR), .CFG_PIN(CFG_PIN), .CFG_MODE(CFG_MODE),
    .OUT_WR(OUT_WR), .OUT_PIN(OUT_PIN), .OUT_LEVEL(OUT_LEVEL), .RD_LEVEL(RD_LEVEL), .RD_MODE(RD_MODE),
    .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE), .DEV_STATE(DEV_STATE), .WAKE_EVT(WAKE_EVT), .STAT_LED_ON(STAT_LED_ON));
  gpsl_pad_model pads (.pad_out(PAD_OUT), .pad_oe(PAD_OE), .ext_lvl(ext_lvl), .ext_en(10'h3ff), .pad_in(PAD_IN));
  // ==========================================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge SYS_CLK);
  endtask : cyc
  task automatic cfg(input logic [3:0] p, input logic [1:0] m);
    @(negedge SYS_CLK);
    {CFG_WR, CFG_PIN, CFG_MODE} = {1'b1, p, m};
    @(negedge SYS_CLK);
    CFG_WR = 1'b0;
  endtask : cfg
  task automatic wr(input logic [3:0] p, input logic l);
    @(negedge SYS_CLK);
    {OUT_WR, OUT_PIN, OUT_LEVEL} = {1'b1, p, l};
    @(negedge SYS_CLK);
    OUT_WR = 1'b0;
  endtask : wr
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // ==========================================================================
  // scenarios
  task automatic t_io();
    chk("oe after reset", 0, PAD_OE);
    chk("mode after reset", 0, RD_MODE);
    ext_lvl[5] = 1'b1;
    wr(4'h5, 1'b0);
    cyc(4);
    chk("input level", 1, RD_LEVEL[5]);
    chk("input oe", 0, PAD_OE[5]);
    wr(4'h3, 1'b1);
    cfg(4'h3, 2'h1);
    cyc(2);
    chk("out oe", 1, PAD_OE[3]);
    chk("out pad", 1, PAD_OUT[3]);
    chk("out read", 1, RD_LEVEL[3]);
    wr(4'h3, 1'b0);
    cyc(2);
    chk("out low", 0, {PAD_OUT[3], RD_LEVEL[3]});
    {CFG_WR, CFG_PIN, CFG_MODE} = {1'b1, 4'h1, 2'h1};
    cyc(1);
    {CFG_PIN, CFG_MODE} = {4'h3, 2'h3};
    cyc(1);
    {CFG_PIN, CFG_MODE} = {4'ha, 2'h1};
    cyc(1);
    CFG_WR = 1'b0;
    cyc(2);
    chk("modes", 20'h00044, RD_MODE);
    $display("pin io test ended");
  endtask : t_io
  task automatic t_alt();
    ALT_OUT[2] = 1'b1;
    ALT_OE[2] = 1'b1;
    cfg(4'h2, 2'h2);
    wr(4'h2, 1'b0);
    cyc(2);
    chk("alt high", 3, {PAD_OE[2], PAD_OUT[2]});
    ALT_OUT[2] = 1'b0;
    cyc(3);
    chk("alt low", 2, {PAD_OE[2], PAD_OUT[2]});
    $display("alternate test ended");
  endtask : t_alt
  task automatic t_led();
    logic [2:0] st [4] = '{3'h1, 3'h4, 3'h0, 3'h6};
    DEV_STATE = 3'h1;
    cyc(3);
    chk("unrouted oe", 0, PAD_OE[0]);
    cfg(4'h0, 2'h2);
    foreach (st[i])
    begin
      DEV_STATE = st[i];
      cyc(4);
      chk("steady pin", {1'b1, i > 1}, {PAD_OE[0], PAD_OUT[0]});
    end
    for (int s = 2; s < 6; s += 3)
    begin
      DEV_STATE = 3'(s);
      n = 0;
      repeat (2 * ON + OFF + 1) @(negedge SYS_CLK) n += STAT_LED_ON;
      chk("blink lit cycles", 2 * ON, n);
      DEV_STATE = 3'h0;
      cyc(3);
    end
    DEV_STATE = 3'h3;
    cyc(6);
    WAKE_EVT = 1'b1;
    cyc(1);
    WAKE_EVT = 1'b0;
    n = 0;
    // a second wake while lit must not stretch the lit period
    repeat (20)
    begin
      @(negedge SYS_CLK);
      n += STAT_LED_ON;
      WAKE_EVT = (n == 1);
    end
    chk("wake lit cycles", ON, n);
    $display("indicator test ended");
  endtask : t_led
  initial
  begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  initial
  begin
    #20000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    {RST_B, CFG_WR, OUT_WR, OUT_LEVEL, WAKE_EVT, CFG_PIN, OUT_PIN, CFG_MODE, DEV_STATE} = '0;
    {ALT_OUT, ALT_OE, ext_lvl} = '0;
    // the x-to-0 step of the clock at time zero must not count as a cycle
    wait (SYS_CLK === 1'b0);
    cyc(2);
    RST_B = 1'b1;
    cyc(3);
    t_io();
    t_alt();
    t_led();
    summarize();
  end
endmodule : gpsl_top_bench
bind gpsl_top gpsl_top_properties #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC)) props (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .CFG_WR(CFG_WR), .CFG_PIN(CFG_PIN), .CFG_MODE(CFG_MODE),
  .RD_LEVEL(RD_LEVEL), .RD_MODE(RD_MODE), .DEV_STATE(DEV_STATE), .WAKE_EVT(WAKE_EVT), .STAT_LED_ON(STAT_LED_ON));
